// ===== hw/spg_defines.svh
// offsets, field positions, reset values and counts for the sector guard
// assumes inclusion by bare name from the guard module
`ifndef SPG_DEFINES_SVH
`define SPG_DEFINES_SVH
`define SPG_NUM_SECTORS 4
`define SPG_BLOCKS_PER_SECTOR 32
`define SPG_BLOCK_SHIFT 5
`define SPG_I2C_BYTES_PER_SECTOR 128
`define SPG_OFS_GUARD_BYTES 2'h0
`define SPG_OFS_PWD_ONE 2'h1
`define SPG_OFS_PWD_TWO 2'h2
`define SPG_OFS_PWD_THREE 2'h3
`define SPG_GUARD_RESET 8'h00
`define SPG_PWD_RESET 32'h0000_0000
`define SPG_BIT_LOCK 0
`define SPG_PROT_LSB 1
`define SPG_PROT_MSB 2
`define SPG_SEL_LSB 3
`define SPG_SEL_MSB 4
`define SPG_PROT_WPWD 2'h0
`define SPG_PROT_OPEN 2'h1
`define SPG_PROT_RWPWD 2'h2
`define SPG_PROT_RPWD 2'h3
`define SPG_SEL_NONE 2'h0
`endif

// ===== hw/spg_pkg.sv
// types shared by the sector guard
// assumes spg_defines.svh is on the include path
package spg_pkg;
  // rf command opcodes seen by the guard
  typedef enum logic [1:0] {
    SPG_CMD_WRITE_PWD,
    SPG_CMD_LOCK,
    SPG_CMD_PRESENT,
    SPG_CMD_READ
  } spg_cmd_t;

  // one rf command as decoded by the front end
  typedef struct packed {
    spg_cmd_t cmd;
    logic [1:0] pwd_idx;   // password number 1..3
    logic [6:0] block;     // block address for read and lock
    logic [3:0] prot_sel;  // bits 4..1 for lock
    logic [31:0] data;     // password value
    logic opt_flag;        // read option flag
  } spg_rf_req_t;

  // answer to an rf command
  typedef struct packed {
    logic done;
    logic error;
    logic rd_ok;
    logic wr_ok;
    logic [7:0] guard;
  } spg_rf_rsp_t;

  // i2c access to the system area
  typedef struct packed {
    logic sys_sel;         // system area select
    logic wr;
    logic [1:0] addr;      // status byte index
    logic [7:0] wdata;
  } spg_i2c_req_t;

  typedef struct packed {
    logic done;
    logic refused;
    logic [7:0] rdata;
  } spg_i2c_rsp_t;
endpackage : spg_pkg

// ===== hw/spg_guard.sv
// per-sector password access guard for the rf and i2c front ends
// assumes one command per strobe, decoded synchronously to mclk
//
// Functional notes
// - status byte: lock, protect, selector, zeros
// - status bytes reset to zero
// - lock and protect code give rights
// - selector links sector to password
// - password write stores 32-bit slot
// - password write needs prior presentation
// - passwords default zero and active
// - lock loads bits 4..1, sets lock
// - locked sector immune to rf change
// - lock on locked sector errors
// - correct password grants linked rights
// - wrong password revokes all password rights
// - i2c reads always, writes need password
// - i2c write reinitialises rf access
// - option flag read returns status byte
// - sector is block address over 32
// - i2c sector spans 128 bytes
`timescale 1ns/10ps
`include "spg_defines.svh"

module spg_guard #(
  parameter int NSEC = `SPG_NUM_SECTORS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic rf_valid,            // one-cycle rf command strobe
  input wire spg_pkg::spg_rf_req_t rf_req,
  output spg_pkg::spg_rf_rsp_t rf_rsp,
  input wire logic i2c_valid,           // one-cycle i2c strobe
  input wire logic i2c_pwd_ok,          // i2c password presented level
  input wire spg_pkg::spg_i2c_req_t i2c_req,
  output spg_pkg::spg_i2c_rsp_t i2c_rsp,
  output logic [31:0] guard_word        // all status bytes, sector 0 low
);

  // status bytes and password slots
  logic [7:0] guard [NSEC];
  logic [7:0] next_guard [NSEC];
  logic [31:0] pwd [3];
  logic [31:0] next_pwd [3];
  // last correctly presented password, zero when none
  logic [1:0] pres;
  logic [1:0] next_pres;
  spg_pkg::spg_rf_rsp_t next_rf_rsp;
  spg_pkg::spg_i2c_rsp_t next_i2c_rsp;
  logic [31:0] next_guard_word;

  // read right from status byte and presentation state
  function automatic logic can_read(input logic [7:0] g,
                                    input logic [1:0] p);
    logic have;
    have = (g[`SPG_SEL_MSB:`SPG_SEL_LSB] != `SPG_SEL_NONE) &&
           (g[`SPG_SEL_MSB:`SPG_SEL_LSB] == p);
    if (!g[`SPG_BIT_LOCK]) begin
      can_read = 1'b1;
    end else begin
      unique case (g[`SPG_PROT_MSB:`SPG_PROT_LSB])
        `SPG_PROT_WPWD, `SPG_PROT_OPEN: can_read = 1'b1;
        `SPG_PROT_RWPWD, `SPG_PROT_RPWD: can_read = have;
      endcase
    end
  endfunction : can_read

  // write right from status byte and presentation state
  function automatic logic can_write(input logic [7:0] g,
                                     input logic [1:0] p);
    logic have;
    have = (g[`SPG_SEL_MSB:`SPG_SEL_LSB] != `SPG_SEL_NONE) &&
           (g[`SPG_SEL_MSB:`SPG_SEL_LSB] == p);
    if (!g[`SPG_BIT_LOCK]) begin
      can_write = 1'b1;
    end else begin
      unique case (g[`SPG_PROT_MSB:`SPG_PROT_LSB])
        `SPG_PROT_OPEN: can_write = 1'b1;
        `SPG_PROT_WPWD, `SPG_PROT_RWPWD: can_write = have;
        `SPG_PROT_RPWD: can_write = 1'b0;
      endcase
    end
  endfunction : can_write

  // sector of a block address; only top bits matter
  function automatic logic [1:0] sector_of(input logic [6:0] blk);
    sector_of = blk[6:`SPG_BLOCK_SHIFT];
  endfunction : sector_of

  logic [1:0] sec;
  assign sec = sector_of(rf_req.block);

  // an accepted i2c status-byte write; it wins over rf in the same cycle
  logic i2c_wr_now;
  assign i2c_wr_now = i2c_valid && i2c_req.sys_sel && i2c_req.wr &&
                      i2c_pwd_ok;

  // next state of guard bytes, passwords and answers
  always_comb begin
    for (int i = 0; i < NSEC; i++) begin
      next_guard[i] = guard[i];
    end
    for (int j = 0; j < 3; j++) begin
      next_pwd[j] = pwd[j];
    end
    next_pres = pres;
    next_rf_rsp = '0;
    next_i2c_rsp = '0;
    // rf commands
    if (rf_valid) begin
      next_rf_rsp.done = 1'b1;
      next_rf_rsp.guard = guard[sec];
      unique case (rf_req.cmd)
        spg_pkg::SPG_CMD_WRITE_PWD: begin
          // slot only writable after its own presentation
          if (rf_req.pwd_idx != 2'h0 && pres == rf_req.pwd_idx) begin
            next_pwd[rf_req.pwd_idx - 2'h1] = rf_req.data;
          end else begin
            next_rf_rsp.error = 1'b1;
          end
        end
        spg_pkg::SPG_CMD_LOCK: begin
          if (guard[sec][`SPG_BIT_LOCK]) begin
            next_rf_rsp.error = 1'b1;
          end else begin
            next_guard[sec] = {3'h0, rf_req.prot_sel, 1'b1};
          end
        end
        spg_pkg::SPG_CMD_PRESENT: begin
          if (rf_req.pwd_idx != 2'h0 &&
              pwd[rf_req.pwd_idx - 2'h1] == rf_req.data) begin
            next_pres = rf_req.pwd_idx;
          end else begin
            next_pres = 2'h0;
            next_rf_rsp.error = 1'b1;
          end
        end
        spg_pkg::SPG_CMD_READ: begin
          // status byte returned only when option flag set
          next_rf_rsp.rd_ok = can_read(guard[sec], pres);
          next_rf_rsp.wr_ok = can_write(guard[sec], pres);
          next_rf_rsp.error = ~next_rf_rsp.rd_ok;
          if (!rf_req.opt_flag) begin
            next_rf_rsp.guard = 8'h00;
          end
        end
      endcase
    end
    // i2c system area; user memory is not this block's business
    // user memory (select low) passes by untouched and unanswered
    if (i2c_valid && i2c_req.sys_sel) begin
      next_i2c_rsp.done = 1'b1;
      next_i2c_rsp.rdata = guard[i2c_req.addr];
      if (i2c_req.wr) begin
        if (i2c_pwd_ok) begin
          // i2c write replaces the byte, and rf rights follow it
          next_guard[i2c_req.addr] = {3'h0, i2c_req.wdata[4:0]};
        end else begin
          next_i2c_rsp.refused = 1'b1;
        end
      end
    end
    for (int k = 0; k < NSEC; k++) begin
      next_guard_word[k*8 +: 8] = next_guard[k];
    end
  end

  // register stage; reset stands in for power-up
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      for (int i = 0; i < NSEC; i++) begin
        guard[i] <= `SPG_GUARD_RESET;
      end
      for (int j = 0; j < 3; j++) begin
        pwd[j] <= `SPG_PWD_RESET;
      end
      pres <= 2'h0;
      rf_rsp <= '0;
      i2c_rsp <= '0;
      guard_word <= '0;
    end else begin
      for (int i = 0; i < NSEC; i++) begin
        guard[i] <= next_guard[i];
      end
      for (int j = 0; j < 3; j++) begin
        pwd[j] <= next_pwd[j];
      end
      pres <= next_pres;
      rf_rsp <= next_rf_rsp;
      i2c_rsp <= next_i2c_rsp;
      guard_word <= next_guard_word;
    end
  end

  // checks on the registered behaviour
  property p_lock_sets;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_LOCK && !guard[sec][0] &&
    !(i2c_wr_now && i2c_req.addr == sec)
    |=> guard_word[8*$past(sec) +: 8] ==
    {3'h0, $past(rf_req.prot_sel), 1'b1};
  endproperty
  a_lock_sets: assert property (p_lock_sets)
    else $error("lock did not load status byte");

  property p_lock_err;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_LOCK && guard[sec][0]
    |=> rf_rsp.error && ($stable(guard_word) || $past(i2c_wr_now));
  endproperty
  a_lock_err: assert property (p_lock_err)
    else $error("lock on locked sector not refused");

  property p_bad_pwd;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_PRESENT &&
    (rf_req.pwd_idx == 2'h0 || pwd[rf_req.pwd_idx - 2'h1] != rf_req.data)
    |=> pres == 2'h0 && rf_rsp.error;
  endproperty
  a_bad_pwd: assert property (p_bad_pwd)
    else $error("wrong password kept rights");

  property p_good_pwd;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_PRESENT &&
    rf_req.pwd_idx != 2'h0 && pwd[rf_req.pwd_idx - 2'h1] == rf_req.data
    |=> pres == $past(rf_req.pwd_idx) && !rf_rsp.error;
  endproperty
  a_good_pwd: assert property (p_good_pwd)
    else $error("correct password not granted");

  property p_pwd_guard;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_WRITE_PWD &&
    pres != rf_req.pwd_idx |=> rf_rsp.error;
  endproperty
  a_pwd_guard: assert property (p_pwd_guard)
    else $error("password written without presentation");

  property p_i2c_refuse;
    @(posedge mclk) disable iff (!rstn)
    i2c_valid && i2c_req.sys_sel && i2c_req.wr && !i2c_pwd_ok
    |=> i2c_rsp.refused && ($stable(guard_word) ||
    $past(rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_LOCK));
  endproperty
  a_i2c_refuse: assert property (p_i2c_refuse)
    else $error("i2c write accepted without password");

  property p_i2c_write;
    @(posedge mclk) disable iff (!rstn)
    i2c_wr_now |=> guard_word[8*$past(i2c_req.addr) +: 8] ==
    {3'h0, $past(i2c_req.wdata[4:0])};
  endproperty
  a_i2c_write: assert property (p_i2c_write)
    else $error("i2c write did not reach status byte");

  property p_top_zero;
    @(posedge mclk) disable iff (!rstn)
    1'b1 |-> guard_word[7:5] == 3'h0 && guard_word[15:13] == 3'h0 &&
    guard_word[23:21] == 3'h0 && guard_word[31:29] == 3'h0;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("reserved status bits set");

  property p_no_sel;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_READ &&
    guard[sec] == 8'h05 |=> !rf_rsp.rd_ok;
  endproperty
  a_no_sel: assert property (p_no_sel)
    else $error("unlinked sector got password rights");

  property p_pwd_store;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_WRITE_PWD &&
    rf_req.pwd_idx != 2'h0 && pres == rf_req.pwd_idx
    |=> pwd[$past(rf_req.pwd_idx) - 2'h1] == $past(rf_req.data) &&
    !rf_rsp.error;
  endproperty
  a_pwd_store: assert property (p_pwd_store)
    else $error("accepted password not stored");

  property p_locked_kept;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && guard[sec][0] && !(i2c_wr_now && i2c_req.addr == sec)
    |=> guard_word[8*$past(sec) +: 8] == $past(guard[sec]);
  endproperty
  a_locked_kept: assert property (p_locked_kept)
    else $error("rf changed a locked status byte");

  property p_open_rights;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_READ && !guard[sec][0]
    |=> rf_rsp.rd_ok && rf_rsp.wr_ok && !rf_rsp.error;
  endproperty
  a_open_rights: assert property (p_open_rights)
    else $error("unlocked sector lost rights");

  property p_never_write;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_READ &&
    guard[sec][2:0] == 3'h7 |=> !rf_rsp.wr_ok;
  endproperty
  a_never_write: assert property (p_never_write)
    else $error("write right on read-only sector");

  property p_opt_guard;
    @(posedge mclk) disable iff (!rstn)
    rf_valid && rf_req.cmd == spg_pkg::SPG_CMD_READ
    |=> rf_rsp.guard ==
    ($past(rf_req.opt_flag) ? $past(guard[sec]) : 8'h00);
  endproperty
  a_opt_guard: assert property (p_opt_guard)
    else $error("read answer carried wrong status byte");

endmodule : spg_guard

// ===== tb/spg_far_end.sv
// far-end model: rf reader and i2c master in front of the guard
// assumes the bench calls its tasks; signals change on rising mclk
`timescale 1ns/10ps
module spg_far_end (
  input wire logic mclk,
  output logic rf_valid,
  output spg_pkg::spg_rf_req_t rf_req,
  output logic i2c_valid,
  output logic i2c_pwd_ok,
  output spg_pkg::spg_i2c_req_t i2c_req
);
  // idle at time zero
  initial begin
    rf_valid = 1'b0;
    rf_req = '0;
    i2c_valid = 1'b0;
    i2c_pwd_ok = 1'b0;
    i2c_req = '0;
  end
  // one rf command; released fields show inverted data, so a stale
  // value can never pass for a held one
  task automatic rf(input spg_pkg::spg_rf_req_t r);
    @(posedge mclk);
    rf_valid <= 1'b1;
    rf_req <= r;
    @(posedge mclk);
    rf_valid <= 1'b0;
    rf_req <= ~r;
  endtask : rf
  // one i2c access; sel picks the status bytes (1) or user memory (0)
  task automatic i2c(input logic sel, input logic wr, input logic [1:0] a,
                     input logic [7:0] d, input logic pok);
    @(posedge mclk);
    i2c_valid <= 1'b1;
    i2c_pwd_ok <= pok;
    i2c_req <= '{sel, wr, a, d};
    @(posedge mclk);
    i2c_valid <= 1'b0;
    i2c_req <= ~{sel, wr, a, d};
  endtask : i2c
endmodule : spg_far_end

// ===== tb/tb_sector_password_access_guard.sv
// self-checking bench for the sector guard, with a reference model
// assumes spg_guard answers one cycle after each strobe
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_sector_password_access_guard;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic rf_valid, i2c_valid, i2c_pwd_ok;
  spg_pkg::spg_rf_req_t rf_req;
  spg_pkg::spg_rf_rsp_t rf_rsp;
  spg_pkg::spg_i2c_req_t i2c_req;
  spg_pkg::spg_i2c_rsp_t i2c_rsp;
  logic [31:0] guard_word;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] gb [4]; // model status bytes
  logic [31:0] pw [3]; // model passwords
  logic [1:0] pres; // last correct presentation, 0 = none
  spg_guard spg_guard_i (.mclk(mclk), .rstn(rstn), .rf_valid(rf_valid),
    .rf_req(rf_req), .rf_rsp(rf_rsp), .i2c_valid(i2c_valid),
    .i2c_pwd_ok(i2c_pwd_ok), .i2c_req(i2c_req), .i2c_rsp(i2c_rsp),
    .guard_word(guard_word));
  spg_far_end spg_far_end_i (.mclk(mclk), .rf_valid(rf_valid),
    .rf_req(rf_req), .i2c_valid(i2c_valid), .i2c_pwd_ok(i2c_pwd_ok),
    .i2c_req(i2c_req));
  // 25 mhz clock
  initial begin
    forever #20 mclk = ~mclk;
  end
  // hang guard, well above the length of all tests
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // expected {read, write} rights of one status byte
  function automatic logic [1:0] rights(input logic [7:0] b,
                                        input logic [1:0] p);
    logic m;
    m = (b[4:3] != 2'h0) && (b[4:3] == p);
    if (!b[0]) return 2'b11;
    case (b[2:1])
      2'h0: return {1'b1, m};
      2'h1: return 2'b11;
      2'h2: return {m, m};
      default: return {m, 1'b0};
    endcase
  endfunction : rights
  function automatic spg_pkg::spg_rf_req_t mk(input int c, input int i,
    input int blk, input int ps, input logic [31:0] d, input logic o);
    return '{spg_pkg::spg_cmd_t'(c), 2'(i), 7'(blk), 4'(ps), d, o};
  endfunction : mk
  // reset the design and the model together
  task automatic do_reset(input int n);
    if (rstn) begin
      @(posedge mclk);
      rstn <= 1'b0;
    end
    repeat (n) @(posedge mclk);
    rstn <= 1'b1;
    foreach (gb[k]) gb[k] = 8'h00;
    foreach (pw[k]) pw[k] = 32'h0;
    pres = 2'h0;
    #1 `CHK("guard_word", 32'h0, guard_word)
  endtask : do_reset
  // one rf command, expected answer worked out first
  task automatic do_rf(input spg_pkg::spg_rf_req_t r);
    logic [1:0] s, ri;
    logic er;
    logic [7:0] g;
    s = r.block[6:5];
    ri = rights(gb[s], pres);
    g = 8'h00;
    case (r.cmd)
      spg_pkg::SPG_CMD_WRITE_PWD: begin
        er = (pres != r.pwd_idx) || (r.pwd_idx == 2'h0);
        if (!er) pw[r.pwd_idx - 1] = r.data;
      end
      spg_pkg::SPG_CMD_LOCK: begin
        er = gb[s][0];
        if (!er) gb[s] = {3'h0, r.prot_sel, 1'b1};
      end
      spg_pkg::SPG_CMD_PRESENT: begin
        er = (r.pwd_idx == 2'h0) || (pw[r.pwd_idx - 1] !== r.data);
        pres = er ? 2'h0 : r.pwd_idx;
      end
      default: begin
        er = !ri[1];
        g = r.opt_flag ? gb[s] : 8'h00;
      end
    endcase
    spg_far_end_i.rf(r);
    #1 `CHK("rf done", 1'b1, rf_rsp.done)
    `CHK("rf error", er, rf_rsp.error)
    if (r.cmd == spg_pkg::SPG_CMD_READ) begin
      `CHK("rd_ok", ri[1], rf_rsp.rd_ok)
      `CHK("wr_ok", ri[0], rf_rsp.wr_ok)
      `CHK("rf guard", g, rf_rsp.guard)
    end
    `CHK("guard_word", {gb[3], gb[2], gb[1], gb[0]}, guard_word)
  endtask : do_rf
  // one i2c access; user-memory accesses must leave the guard silent
  task automatic do_i2c(input logic sel, input logic wr,
                        input logic [1:0] a, input logic [7:0] d,
                        input logic pok);
    logic [7:0] rd;
    rd = gb[a];
    if (sel && wr && pok) gb[a] = d & 8'h1f;
    spg_far_end_i.i2c(sel, wr, a, d, pok);
    #1 `CHK("i2c done", sel, i2c_rsp.done)
    `CHK("i2c refused", sel && wr && !pok, i2c_rsp.refused)
    if (sel && !wr) `CHK("i2c rdata", rd, i2c_rsp.rdata)
    `CHK("guard_word", {gb[3], gb[2], gb[1], gb[0]}, guard_word)
  endtask : do_i2c
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    void'($urandom(32'hac09324b));
    do_reset(10);
    for (int s = 0; s < 4; s++) do_rf(mk(3, 0, s * 32 + 31, 0, 0, 1));
    $display("test reset done");
    do_rf(mk(0, 1, 0, 0, 32'h1234, 0)); // refused before presenting
    do_rf(mk(2, 1, 0, 0, 32'h0, 0)); // default zero password
    do_rf(mk(0, 1, 0, 0, 32'h1234, 0));
    do_rf(mk(2, 2, 0, 0, 32'h5, 0)); // wrong, rights dropped
    do_rf(mk(0, 1, 0, 0, 32'h9, 0));
    do_rf(mk(2, 1, 0, 0, 32'h1234, 0));
    $display("test passwords done");
    for (int c = 0; c < 4; c++) do_rf(mk(1, 0, c * 32, 4 + c, 0, 0));
    do_rf(mk(1, 0, 1, 0, 0, 0)); // relock refused
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) do_rf(mk(3, 0, s * 32, 0, 0, 1));
      do_rf(mk(2, 1, 0, 0, 32'h77, 0));
    end
    $display("test locks done");
    for (int a = 0; a < 4; a++) do_i2c(1'b1, 1'b0, 2'(a), 8'h00, 1'b0);
    do_i2c(1'b1, 1'b1, 2'h0, 8'he0, 1'b0);
    do_i2c(1'b1, 1'b1, 2'h0, 8'hfb, 1'b1);
    do_i2c(1'b1, 1'b1, 2'h1, 8'he0, 1'b1);
    do_i2c(1'b0, 1'b1, 2'h2, 8'h1f, 1'b1); // user memory, left alone
    do_rf(mk(1, 0, 32, 2, 0, 0)); // relock after i2c reinit
    do_rf(mk(2, 1, 0, 0, 32'h1234, 0)); // password 1 back in force
    do_rf(mk(3, 0, 32, 0, 0, 1)); // unlinked sector stays closed
    $display("test i2c done");
    repeat (400) begin
      if ($urandom % 4 == 0)
        do_i2c($urandom % 8 != 0, 1'($urandom), 2'($urandom),
          8'($urandom), 1'($urandom));
      else
        do_rf(mk($urandom % 4, 1 + $urandom % 3, $urandom % 128,
          $urandom % 16, $urandom % 2 ? pw[$urandom % 3] : $urandom,
          1'($urandom)));
    end
    $display("test random done");
    do_rf(mk(2, 1, 0, 0, pw[0], 0));
    do_reset(2);
    do_rf(mk(1, 0, 32, 4, 0, 0)); // linked to the password just given
    do_rf(mk(3, 0, 33, 0, 0, 1)); // presentation forgotten by reset
    $display("test second reset done");
    summarize();
  end
endmodule : tb_sector_password_access_guard
